// >>> rtl/ddsl_loader.v
// serial word loader and latch bank for a dual twelve-bit converter
`include "ddsl_map.vh"
`timescale 1ns/100ps
`default_nettype none
module ddsl_loader (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // serial link pins
   input  wire        cs_n,
   input  wire        sclk,
   input  wire        sdin,
   // channel codes
   output reg  [11:0] chan_a_code,
   output reg  [11:0] chan_b_code,
   output reg  [11:0] buffer_code,
   // configuration
   output reg         settling_speed_select,
   output reg         power_down_select,
   output reg         reference_select_hi,
   output reg         reference_select_lo,
   // update strobe
   output reg         latch_update
);
   wire cs_lvl;
   wire cs_rise;
   wire sclk_rise;
   wire sclk_fall;
   wire din_lvl;

   reg [15:0] shift_r;
   reg [4:0]  count_r;
   reg        pend_r;

   // select idles high, so it resets high
   ddsl_sync #(
      .RST_VAL (1'b1)
   ) u_cs (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .async_in  (cs_n),
      .level_out (cs_lvl),
      .rise_out  (cs_rise),
      .fall_out  ()
   );

   // serial clock idles high, so it resets high
   ddsl_sync #(
      .RST_VAL (1'b1)
   ) u_ck (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .async_in  (sclk),
      .level_out (),
      .rise_out  (sclk_rise),
      .fall_out  (sclk_fall)
   );

   ddsl_sync u_dat (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .async_in  (sdin),
      .level_out (din_lvl),
      .rise_out  (),
      .fall_out  ()
   );

   // data lags clock by one flop so it is sampled before any change
   reg din_d_r;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         din_d_r <= 1'b0;
      else
         din_d_r <= din_lvl;
   end

   // RULE9 RULE10 word to latch decode
   task load_word;
      input [15:0] w;
      begin
         // RULE11 speed and power bits
         settling_speed_select <= w[`DDSL_BIT_SPEED];
         power_down_select     <= w[`DDSL_BIT_POWER];
         case ({w[`DDSL_BIT_SEL_HI], w[`DDSL_BIT_SEL_LO]})
            // RULE8 unsigned twelve bit codes
            `DDSL_SEL_CHB_BUF: begin
               chan_b_code <= w[11:0];
               buffer_code <= w[11:0];
            end
            `DDSL_SEL_BUF: begin
               buffer_code <= w[11:0];
            end
            `DDSL_SEL_CHA_XFER: begin
               chan_a_code <= w[11:0];
               chan_b_code <= buffer_code;
            end
            default: begin
               // RULE12 reference bits only
               reference_select_hi <= w[1];
               reference_select_lo <= w[0];
            end
         endcase
      end
   endtask

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // RULE7 clear all latches
         shift_r               <= 16'h0000;
         count_r               <= 5'h00;
         pend_r                <= 1'b0;
         chan_a_code           <= `DDSL_CODE_RST;
         chan_b_code           <= `DDSL_CODE_RST;
         buffer_code           <= `DDSL_CODE_RST;
         settling_speed_select <= 1'b0;
         power_down_select     <= 1'b0;
         reference_select_hi   <= 1'b0;
         reference_select_lo   <= 1'b0;
         latch_update          <= 1'b0;
      end else begin
         latch_update <= 1'b0;
         if (cs_lvl) begin
            // RULE13 idle while deselected
            count_r <= 5'h00;
            pend_r  <= 1'b0;
            // RULE2 short frame loads on cs rise
            if (cs_rise && pend_r) begin
               load_word(shift_r);
               latch_update <= 1'b1;
            end
         end else begin
            if (sclk_fall && count_r != `DDSL_CNT_LAST) begin
               // RULE1 msb first shift
               shift_r <= {shift_r[14:0], din_d_r};
               count_r <= count_r + 5'h01;
               pend_r  <= 1'b1;
            end else if (sclk_rise && count_r == `DDSL_CNT_LAST && pend_r) begin
               // RULE4 update on sixteenth rise
               load_word(shift_r);
               latch_update <= 1'b1;
               pend_r       <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/ddsl_map.vh
// constants for the dual converter serial loader
//Contract
//RULE1: shift data on falling edges, msb first
//RULE2: after 16 bits or cs rise, load latch
//RULE3: host holds cs low past sixteenth edge
//RULE4: latch updates on sixteenth rising edge
//RULE5: host drops cs before first bit
//RULE6: byte hosts send two bytes per word
//RULE7: reset clears every latch to zero
//RULE8: channel codes are unsigned twelve bit
//RULE9: four program bits then twelve data bits
//RULE10: latch select decodes to four targets
//RULE11: speed one fast, power one down
//RULE12: control low bits select reference source
//RULE13: cs high ignores clock and data
`ifndef DDSL_MAP_VH
`define DDSL_MAP_VH
`define DDSL_WORD_BITS      16
`define DDSL_CODE_BITS      12
`define DDSL_BIT_SEL_HI     15
`define DDSL_BIT_SPEED      14
`define DDSL_BIT_POWER      13
`define DDSL_BIT_SEL_LO     12
`define DDSL_SEL_CHB_BUF    2'b00
`define DDSL_SEL_BUF        2'b01
`define DDSL_SEL_CHA_XFER   2'b10
`define DDSL_SEL_CTRL       2'b11
`define DDSL_REF_EXT        2'b00
`define DDSL_REF_1V024      2'b01
`define DDSL_REF_2V048      2'b10
`define DDSL_CODE_RST       12'h000
`define DDSL_CNT_LAST       5'h10
`endif

// >>> rtl/ddsl_sync.v
// two-flop synchroniser with edge detection on the synced level
`timescale 1ns/100ps
`default_nettype none
module ddsl_sync #(
   // level held in reset, set to the pin's idle level so no false edge follows
   parameter RST_VAL = 1'b0
) (
   // clock and reset
   input  wire sys_clk,
   input  wire rst_n,
   // asynchronous level in
   input  wire async_in,
   // synced level and edges
   output wire level_out,
   output wire rise_out,
   output wire fall_out
);
   reg meta_r;
   reg sync_r;
   reg last_r;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
         last_r <= RST_VAL;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign level_out = sync_r;
   assign rise_out  = sync_r & ~last_r;
   assign fall_out  = ~sync_r & last_r;
endmodule
`default_nettype wire

// >>> tb/ddsl_host.sv
// host serial port model driving the loader pins
`timescale 1ns/100ps
`default_nettype none
module ddsl_host (
   input  wire logic sys_clk,
   output logic      cs_n = 1,
   output logic      sclk = 1,
   output logic      sdin = 0
);
   task send(input [15:0] w, input integer k, h, input bit nz);
      integer j;
      repeat (nz ? 4 : 0) @(negedge sys_clk) {sclk, sdin} = ~{sclk, sdin};
      @(negedge sys_clk) cs_n = 0;
      for (j = 15; j > 15 - k; j--) begin
         sdin = w[j];
         repeat (h) @(negedge sys_clk);
         sclk = 0;
         repeat (h) @(negedge sys_clk);
         sclk = 1;
      end
      repeat (8) @(negedge sys_clk);
      cs_n = 1;
      sdin = ~sdin;
      repeat (8) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// >>> tb/ddsl_loader_monitor.sv
// port checker for the serial loader
`timescale 1ns/100ps
`default_nettype none
module ddsl_loader_monitor (
   input wire logic        sys_clk, rst_n, cs_n, sclk, sdin, latch_update,
   input wire logic        settling_speed_select, power_down_select,
   input wire logic        reference_select_hi, reference_select_lo,
   input wire logic [11:0] chan_a_code, chan_b_code, buffer_code
);
   reg  [4:0]  n_r;
   reg         sk_r;
   reg  [15:0] sh_r;
   wire [35:0] cd = {chan_a_code, chan_b_code, buffer_code};
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) {n_r, sk_r, sh_r} <= 22'h000000;
      else begin
         sk_r <= sclk;
         if (cs_n) n_r <= 5'h00;
         else if (sclk && !sk_r) n_r <= n_r + 5'h01;
         if (!cs_n && !sclk && sk_r) sh_r <= {sh_r[14:0], sdin};
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence last_rise; $rose(n_r == 5'h10); endsequence
   sequence quiet; cs_n [*8]; endsequence
   pulse_one_a:
      assert property (latch_update |=> !latch_update) else $error("long pulse");
   cause_a:
      assert property ($changed(cd) |-> latch_update) else $error("stray change");
   upd_time_a:
      assert property (last_rise |-> ##[1:6] latch_update) else $error("late update");
   no_early_a:
      assert property (!cs_n && n_r > 0 && n_r < 5'h10 |-> !latch_update) else $error("early");
   idle_a:
      assert property (quiet |=> $stable(cd)) else $error("idle change");
   xfer_a:
      assert property (latch_update && $changed(chan_a_code) |->
         chan_b_code == $past(buffer_code) && $stable(buffer_code)) else $error("bad xfer");
   pair_a:
      assert property ($changed(chan_b_code) |-> chan_b_code == buffer_code) else $error("b");
   mode_a:
      assert property (latch_update && n_r == 5'h10 |->
         {settling_speed_select, power_down_select} == sh_r[14:13]) else $error("mode");
endmodule
bind ddsl_loader ddsl_loader_monitor mon (.*);
`default_nettype wire

// >>> tb/ddsl_loader_tb_top.sv
// bench for the serial loader
`timescale 1ns/100ps
`default_nettype none
module ddsl_loader_tb_top;
   logic        sys_clk = 0, rst_n = 0;
   wire         cs_n, sclk, sdin, sp, pd, rh, rl, lu;
   wire  [11:0] ca, cb, cf;
   logic [39:0] q[$];
   logic [11:0] ea = 0, eb = 0, ef = 0;
   logic [1:0]  er = 0;
   logic [15:0] sr = 0, w;
   integer      seed = 32'hd122, fails = 0, num_checks = 0, i, k;
   ddsl_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .sdin(sdin));
   ddsl_loader dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdin(sdin),
      .chan_a_code(ca), .chan_b_code(cb), .buffer_code(cf), .settling_speed_select(sp),
      .power_down_select(pd), .reference_select_hi(rh), .reference_select_lo(rl),
      .latch_update(lu));
   initial forever #12.5 sys_clk = ~sys_clk;
   task chk(input [39:0] s, e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH outputs exp %h seen %h", e, s);
      end
   endtask
   task stop_test;
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task note(input [15:0] p);
      case ({p[15], p[12]})
         2'b00: {eb, ef} = {2{p[11:0]}};
         2'b01: ef = p[11:0];
         2'b10: {ea, eb} = {p[11:0], ef};
         default: er = p[1:0];
      endcase
      q.push_back({ea, eb, ef, p[14:13], er});
   endtask
   initial begin
      repeat (5) @(negedge sys_clk);
      rst_n = 1;
      repeat (3) @(negedge sys_clk);
      chk({ca, cb, cf, sp, pd, rh, rl}, 40'h0);
      for (i = 0; i < 60; i++) begin
         w = $random(seed);
         {w[15], w[12]} = i[1:0];
         k = (i % 8 == 7) ? 5 : 16;
         sr = (sr << k) | (w >> (16 - k));
         note(sr);
         host.send(w, k, (i % 2) ? 4 : 12, i % 3 == 0);
      end
      for (i = 0; i < 100 && q.size() > 0; i++) @(negedge sys_clk);
      if (q.size() > 0) fails++;
      stop_test;
   end
   always @(negedge sys_clk) if (lu) begin
      if (q.size() == 0) fails++;
      else chk({ca, cb, cf, sp, pd, rh, rl}, q.pop_front());
   end
endmodule
`default_nettype wire
